// ---- rtl/byte_alu_pkg.sv ----
package byte_alu_pkg;
	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int NIB_LO_MSB = 3;
	localparam int NIB_HI_LSB = 4;
	localparam int NIB_HI_MSB = 7;
	// ----------------------------------------
	// destination select and reset values
	// ----------------------------------------
	localparam logic DEST_ACC = 1'b0;
	localparam logic DEST_FILE = 1'b1;
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic FLAG_RESET = 1'b0;
	localparam logic [6:0] ADDR_RESET = 7'h00;
	// ----------------------------------------
	// operation codes
	// ----------------------------------------
	typedef enum logic [2:0] {
		op_none,
		op_sub_acc_from_file,
		op_xor_literal_into_acc,
		op_swap_file_nibbles,
		op_xor_acc_with_file
	} alu_op_t;
endpackage

// ---- rtl/alu_result_core.sv ----
`timescale 1ns/1ps
module alu_result_core (
	input wire byte_alu_pkg::alu_op_t op_in,
	input wire logic [7:0] acc_in,
	input wire logic [7:0] file_in,
	input wire logic [7:0] literal_in,
	output logic [7:0] result_out,
	output logic carry_out,
	output logic digit_carry_out
);
	import byte_alu_pkg::*;

	always_comb begin
		result_out = acc_in;
		carry_out = (acc_in <= file_in);
		digit_carry_out = (acc_in[NIB_LO_MSB:0] <= file_in[NIB_LO_MSB:0]);
		case (op_in)
			op_sub_acc_from_file: result_out = file_in - acc_in;
			op_xor_literal_into_acc: result_out = acc_in ^ literal_in;
			op_swap_file_nibbles: result_out = {file_in[NIB_LO_MSB:0], file_in[NIB_HI_MSB:NIB_HI_LSB]};
			op_xor_acc_with_file: result_out = acc_in ^ file_in;
			default: result_out = acc_in;
		endcase
	end
endmodule

// ---- rtl/byte_alu_sub_xor_swap.sv ----
`timescale 1ns/1ps
module byte_alu_sub_xor_swap (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic op_valid_in,
	input wire byte_alu_pkg::alu_op_t op_in,
	input wire logic dest_in,
	input wire logic [6:0] file_addr_in,
	input wire logic [7:0] literal_in,
	input wire logic [7:0] file_data_in,
	output logic [7:0] acc_out,
	output logic file_we_out,
	output logic [6:0] file_waddr_out,
	output logic [7:0] file_wdata_out,
	output logic carry_out,
	output logic digit_carry_flag_out,
	output logic zero_out
);
	import byte_alu_pkg::*;

	logic [7:0] next_result;
	logic next_carry;
	logic next_dc;
	logic to_file;

	// ----------------------------------------
	// result datapath
	// ----------------------------------------
	alu_result_core u_core (
		.op_in(op_in),
		.acc_in(acc_out),
		.file_in(file_data_in),
		.literal_in(literal_in),
		.result_out(next_result),
		.carry_out(next_carry),
		.digit_carry_out(next_dc)
	);

	// literal op always lands in the accumulator, whatever dest says
	assign to_file = op_valid_in && dest_in == DEST_FILE && op_in != op_xor_literal_into_acc && op_in != op_none;

	// ----------------------------------------
	// accumulator
	// ----------------------------------------
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			acc_out <= ACC_RESET;
		end else if (op_valid_in && op_in != op_none && !to_file) begin
			acc_out <= next_result;
		end
	end

	// ----------------------------------------
	// file write-back
	// ----------------------------------------
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			file_we_out <= 1'b0;
			file_waddr_out <= ADDR_RESET;
			file_wdata_out <= ACC_RESET;
		end else begin
			file_we_out <= to_file;
			file_waddr_out <= file_addr_in;
			file_wdata_out <= next_result;
		end
	end

	// ----------------------------------------
	// status flags
	// ----------------------------------------
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			carry_out <= FLAG_RESET;
			digit_carry_flag_out <= FLAG_RESET;
		end else if (op_valid_in && op_in == op_sub_acc_from_file) begin
			carry_out <= next_carry;
			digit_carry_flag_out <= next_dc;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			zero_out <= FLAG_RESET;
		end else if (op_valid_in && op_in != op_none && op_in != op_swap_file_nibbles) begin
			zero_out <= (next_result == 8'h00);
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_sub_carry;
		@(posedge clk_sys_in) disable iff (rst_in)
		(op_valid_in && op_in == op_sub_acc_from_file) |=> carry_out == $past(acc_out <= file_data_in);
	endproperty
	a_sub_carry: assert property (p_sub_carry) else $error("carry wrong after subtract");

	property p_sub_dc;
		@(posedge clk_sys_in) disable iff (rst_in)
		(op_valid_in && op_in == op_sub_acc_from_file)
		|=> digit_carry_flag_out == $past(acc_out[3:0] <= file_data_in[3:0]);
	endproperty
	a_sub_dc: assert property (p_sub_dc) else $error("digit carry wrong after subtract");

	property p_sub_acc;
		@(posedge clk_sys_in) disable iff (rst_in)
		(op_valid_in && op_in == op_sub_acc_from_file && !dest_in)
		|=> acc_out == 8'($past(file_data_in) - $past(acc_out));
	endproperty
	a_sub_acc: assert property (p_sub_acc) else $error("subtract result wrong");

	property p_sub_file;
		@(posedge clk_sys_in) disable iff (rst_in)
		(op_valid_in && op_in == op_sub_acc_from_file && dest_in)
		|=> file_we_out && file_wdata_out == 8'($past(file_data_in) - acc_out) && $stable(acc_out);
	endproperty
	a_sub_file: assert property (p_sub_file) else $error("subtract write-back wrong");

	property p_xorl;
		@(posedge clk_sys_in) disable iff (rst_in)
		(op_valid_in && op_in == op_xor_literal_into_acc)
		|=> !file_we_out && acc_out == ($past(acc_out) ^ $past(literal_in)) && $stable(carry_out);
	endproperty
	a_xorl: assert property (p_xorl) else $error("literal xor wrong");

	property p_swap;
		@(posedge clk_sys_in) disable iff (rst_in)
		(op_valid_in && op_in == op_swap_file_nibbles && dest_in)
		|=> file_wdata_out == {$past(file_data_in[3:0]), $past(file_data_in[7:4])} && $stable(zero_out);
	endproperty
	a_swap: assert property (p_swap) else $error("nibble swap wrong");

	property p_xorf;
		@(posedge clk_sys_in) disable iff (rst_in)
		(op_valid_in && op_in == op_xor_acc_with_file && !dest_in)
		|=> acc_out == ($past(acc_out) ^ $past(file_data_in)) && !file_we_out;
	endproperty
	a_xorf: assert property (p_xorf) else $error("file xor wrong");

	property p_zero;
		@(posedge clk_sys_in) disable iff (rst_in)
		(op_valid_in && op_in == op_xor_acc_with_file && dest_in)
		|=> zero_out == (file_wdata_out == 8'h00) && file_wdata_out == ($past(acc_out) ^ $past(file_data_in));
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");

	// ----------------------------------------
	// step sequences
	// ----------------------------------------
	sequence s_sub_taken;
		op_valid_in && op_in == op_sub_acc_from_file;
	endsequence

	sequence s_xorl_taken;
		op_valid_in && op_in == op_xor_literal_into_acc;
	endsequence

	sequence s_swap_taken;
		op_valid_in && op_in == op_swap_file_nibbles;
	endsequence

	sequence s_xorf_taken;
		op_valid_in && op_in == op_xor_acc_with_file;
	endsequence

	// refused cycle leaves acc and all flags alone and writes nothing back; file_waddr_out and file_wdata_out still reload
	sequence s_idle;
		!op_valid_in || op_in == op_none;
	endsequence

	sequence s_carries_kept;
		$stable(carry_out) && $stable(digit_carry_flag_out);
	endsequence

	// write-back hits the operand's own address, acc spared
	sequence s_written_back;
		file_we_out && file_waddr_out == $past(file_addr_in) && $stable(acc_out);
	endsequence

	// ----------------------------------------
	// checks built from the steps
	// ----------------------------------------
	property p_idle;
		@(posedge clk_sys_in) disable iff (rst_in)
		s_idle |=> (!file_we_out && $stable(acc_out) && $stable(zero_out)) ##0 s_carries_kept;
	endproperty
	a_idle: assert property (p_idle) else $error("refused cycle changed state");

	property p_sub_zero;
		@(posedge clk_sys_in) disable iff (rst_in)
		s_sub_taken |=> zero_out == ($past(file_data_in) == $past(acc_out));
	endproperty
	a_sub_zero: assert property (p_sub_zero) else $error("zero flag wrong after subtract");

	property p_sub_addr;
		@(posedge clk_sys_in) disable iff (rst_in)
		s_sub_taken ##0 dest_in |=> s_written_back;
	endproperty
	a_sub_addr: assert property (p_sub_addr) else $error("subtract write-back address wrong");

	property p_xorl_zero;
		@(posedge clk_sys_in) disable iff (rst_in)
		s_xorl_taken |=> (zero_out == (($past(acc_out) ^ $past(literal_in)) == 8'h00)) ##0 s_carries_kept;
	endproperty
	a_xorl_zero: assert property (p_xorl_zero) else $error("literal xor flags wrong");

	property p_swap_acc;
		@(posedge clk_sys_in) disable iff (rst_in)
		s_swap_taken ##0 !dest_in
		|=> (acc_out == {$past(file_data_in[3:0]), $past(file_data_in[7:4])} && !file_we_out && $stable(zero_out))
		##0 s_carries_kept;
	endproperty
	a_swap_acc: assert property (p_swap_acc) else $error("nibble swap into acc wrong");

	property p_swap_file;
		@(posedge clk_sys_in) disable iff (rst_in)
		s_swap_taken ##0 dest_in |=> s_written_back ##0 $stable(zero_out) ##0 s_carries_kept;
	endproperty
	a_swap_file: assert property (p_swap_file) else $error("nibble swap write-back wrong");

	property p_xorf_file;
		@(posedge clk_sys_in) disable iff (rst_in)
		s_xorf_taken ##0 dest_in |=> s_written_back ##0 s_carries_kept;
	endproperty
	a_xorf_file: assert property (p_xorf_file) else $error("file xor write-back wrong");

	property p_xorf_flags;
		@(posedge clk_sys_in) disable iff (rst_in)
		s_xorf_taken |=> (zero_out == (($past(acc_out) ^ $past(file_data_in)) == 8'h00)) ##0 s_carries_kept;
	endproperty
	a_xorf_flags: assert property (p_xorf_flags) else $error("file xor flags wrong");
endmodule

// ---- verif/file_regs_model.sv ----
`timescale 1ns/1ps
module file_regs_model (
	input wire logic clk_sys_in,
	input wire logic we_in,
	input wire logic [6:0] waddr_in,
	input wire logic [7:0] wdata_in,
	input wire logic [6:0] raddr_in,
	output logic [7:0] rdata_out
);
	logic [7:0] mem [128];
	initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 8'h25);
	always @(posedge clk_sys_in) if (we_in) mem[waddr_in] <= wdata_in;
	// forward a pending write: the core may read it back the very next cycle
	assign rdata_out = (we_in && waddr_in == raddr_in) ? wdata_in : mem[raddr_in];
endmodule

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	import byte_alu_pkg::*;
	logic clk_sys_in = 1'b0, rst_in = 1'b1, op_valid_in = 1'b0, dest_in = 1'b0;
	alu_op_t op_in = op_none;
	logic [6:0] file_addr_in = 7'h00, file_waddr_out;
	logic [7:0] literal_in = 8'h00, file_data_in, acc_out, file_wdata_out, fm [128];
	logic [7:0] acc = 8'h00;
	logic file_we_out, carry_out, digit_carry_flag_out, zero_out;
	logic c = 1'b0, dc = 1'b0, z = 1'b0;
	int num_errors = 0, tests_run = 0;
	always #10 clk_sys_in = ~clk_sys_in;
	byte_alu_sub_xor_swap dut_u (.clk_sys_in, .rst_in, .op_valid_in, .op_in, .dest_in, .file_addr_in, .literal_in,
		.file_data_in, .acc_out, .file_we_out, .file_waddr_out, .file_wdata_out, .carry_out, .digit_carry_flag_out,
		.zero_out);
	file_regs_model part_u (.clk_sys_in, .we_in(file_we_out), .waddr_in(file_waddr_out),
		.wdata_in(file_wdata_out), .raddr_in(file_addr_in), .rdata_out(file_data_in));
	// ----------------------------------------
	// checks
	// ----------------------------------------
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		tests_run++;
		if (s !== e) begin
			$display("unexpected %s: expected %h, seen %h", n, e, s);
			num_errors++;
		end
	endtask
	function automatic logic [7:0] exp_result(input alu_op_t o, input logic [7:0] w, input logic [7:0] f,
		input logic [7:0] k);
		case (o)
			op_sub_acc_from_file: return f - w;
			op_xor_literal_into_acc: return w ^ k;
			op_swap_file_nibbles: return {f[3:0], f[7:4]};
			default: return w ^ f;
		endcase
	endfunction
	task automatic run(input logic v, input alu_op_t o, input logic d, input logic [6:0] a, input logic [7:0] k);
		logic [7:0] f, r;
		logic w;
		op_valid_in = v;
		op_in = o;
		dest_in = d;
		file_addr_in = a;
		literal_in = k;
		f = fm[a];
		w = 1'b0;
		if (v && o != op_none) begin
			r = exp_result(o, acc, f, k);
			if (o == op_sub_acc_from_file) begin
				c = acc <= f;
				dc = acc[3:0] <= f[3:0];
			end
			if (o != op_swap_file_nibbles) z = r == 8'h00;
			w = d && o != op_xor_literal_into_acc;
			if (w) fm[a] = r;
			else acc = r;
		end
		@(negedge clk_sys_in);
		chk("acc", acc, acc_out);
		chk("flags", {5'h0, c, dc, z}, {5'h0, carry_out, digit_carry_flag_out, zero_out});
		chk("file_we", {7'h0, w}, {7'h0, file_we_out});
		if (w) chk("file_wdata", r, file_wdata_out);
		if (w) chk("file_waddr", {1'b0, a}, {1'b0, file_waddr_out});
	endtask
	// idle first so no write-back is cut off by the reset
	task automatic do_reset;
		if (!rst_in) run(1'b0, op_none, 1'b0, 7'h00, 8'h00);
		rst_in = 1'b1;
		repeat (10) @(negedge clk_sys_in);
		rst_in = 1'b0;
		acc = 8'h00;
		c = 1'b0;
		dc = 1'b0;
		z = 1'b0;
		run(1'b0, op_none, 1'b0, 7'h00, 8'h00);
	endtask
	task automatic end_of_test;
		$display("comparisons %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		for (int i = 0; i < 128; i++) fm[i] = 8'(i * 8'h25);
		void'($urandom(32'hf8b1));
		do_reset();
		run(1'b1, op_xor_literal_into_acc, 1'b1, 7'h05, 8'h35);
		run(1'b1, op_xor_literal_into_acc, 1'b0, 7'h05, 8'h35);
		run(1'b1, op_xor_acc_with_file, 1'b0, 7'h09, 8'h00);
		run(1'b1, op_sub_acc_from_file, 1'b0, 7'h09, 8'h00);
		run(1'b1, op_swap_file_nibbles, 1'b1, 7'h7f, 8'h00);
		run(1'b1, op_sub_acc_from_file, 1'b1, 7'h7f, 8'h00);
		run(1'b1, op_xor_literal_into_acc, 1'b0, 7'h00, 8'hff);
		run(1'b1, op_sub_acc_from_file, 1'b0, 7'h01, 8'h00);
		for (int j = 0; j < 2; j++) begin
			repeat (400) run($urandom_range(7, 0) != 0, alu_op_t'($urandom_range(4, 0)), 1'($urandom),
				7'($urandom_range(15, 0)), 8'($urandom));
			do_reset();
		end
		end_of_test();
	end
endmodule
